// ### occr_params.svh
`ifndef OCCR_PARAMS_SVH
`define OCCR_PARAMS_SVH
// byte offsets of the two configuration words
`define OCCR_SYNC_OUT7_OFS 12'h000
`define OCCR_SEC_PATH_OFS 12'h004
`define OCCR_SYNC_OUT7_RST 8'hf6
`define OCCR_SEC_PATH_RST 8'h00
// field positions, sync_and_out7_config
`define OCCR_MFS_EN_BIT 7
`define OCCR_FS_EN_BIT 6
`define OCCR_BITS_EN_BIT 5
`define OCCR_COMP_EN_BIT 4
// field positions, secondary_path_pll_config
`define OCCR_AUTO_MUTE_BIT 6
`define OCCR_DUTY_BIT 5
// writable bits of secondary_path_pll_config, top bit unused
`define OCCR_SEC_PATH_MASK 8'h7f
`define OCCR_RESP_OKAY 2'b00
`define OCCR_RESP_SLVERR 2'b10
`endif

// ### occr_pkg.sv
package occr_pkg;
   typedef enum logic [3:0] {
      OUT7_OFF = 4'h0,
      OUT7_2K = 4'h1,
      OUT7_8K = 4'h2,
      OUT7_DIG1 = 4'h3
   } occr_out7_base_type;

   typedef struct packed {
      logic multiframe_sync_out_enable;
      logic frame_sync_out_enable;
      logic bits_out_enable;
      logic composite_out_enable;
      logic composite_duty_select;
      logic out7_enable;
      logic out7_from_main_pll;
      logic out7_from_secondary_pll;
      logic [3:0] out7_select;
   } occr_out_ctrl_type;
endpackage

// ### occr_output_clock_config_regs.sv
// How it works
// - 2 kHz multiframe sync driven only when enabled
// - 8 kHz frame sync driven only when enabled
// - bits clock output follows its enable
// - composite clock output follows its enable
// - four-bit code picks output seven source
// - auto mute kills bits/composite on input fail
// - duty bit picks 50:50 or 5:8 composite
// - secondary path register read/write, top bit unused
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "occr_params.svh"
module occr_output_clock_config_regs (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic secondary_inputs_failed,
   output occr_pkg::occr_out_ctrl_type out_ctrl
);
   import occr_pkg::*;

   logic [7:0] sync_cfg_r, sync_cfg_nxt;
   logic [7:0] sec_cfg_r, sec_cfg_nxt;
   logic [11:0] awaddr_r, awaddr_nxt;
   logic aw_held_r, aw_held_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic wstrb0_r, wstrb0_nxt;
   logic w_held_r, w_held_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic fail_meta_r, fail_sync_r;
   occr_out_ctrl_type out_r, out_nxt;
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic arready_r, arready_nxt;

   logic aw_take, w_take, ar_take, do_write;
   logic [11:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_lane0;
   logic mute;
   logic hit_sync, hit_sec;

   // single write in flight: a held half or a waiting response drops that ready
   assign aw_take = s_axi_awvalid && awready_r;
   assign w_take = s_axi_wvalid && wready_r;
   assign ar_take = s_axi_arvalid && arready_r;

   always_comb begin
      wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
      wr_data = w_held_r ? wdata_r : s_axi_wdata[7:0];
      wr_lane0 = w_held_r ? wstrb0_r : s_axi_wstrb[0];
      do_write = (aw_held_r || aw_take) && (w_held_r || w_take);
      hit_sync = {wr_addr[11:2], 2'b00} == `OCCR_SYNC_OUT7_OFS;
      hit_sec = {wr_addr[11:2], 2'b00} == `OCCR_SEC_PATH_OFS;
   end

   always_comb begin
      sync_cfg_nxt = sync_cfg_r;
      sec_cfg_nxt = sec_cfg_r;
      awaddr_nxt = awaddr_r;
      aw_held_nxt = aw_held_r;
      wdata_nxt = wdata_r;
      wstrb0_nxt = wstrb0_r;
      w_held_nxt = w_held_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (aw_take) begin
         awaddr_nxt = s_axi_awaddr;
         aw_held_nxt = 1'b1;
      end
      if (w_take) begin
         wdata_nxt = s_axi_wdata[7:0];
         wstrb0_nxt = s_axi_wstrb[0];
         w_held_nxt = 1'b1;
      end
      if (do_write) begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = `OCCR_RESP_OKAY;
         // only byte lane 0 carries register bits; upper lanes are ignored
         if (hit_sync) begin
            if (wr_lane0) begin
               sync_cfg_nxt = wr_data;
            end
         end else if (hit_sec) begin
            if (wr_lane0) begin
               sec_cfg_nxt = wr_data & `OCCR_SEC_PATH_MASK;
            end
         end else begin
            bresp_nxt = `OCCR_RESP_SLVERR;
         end
      end
      // ready follows the state after this edge, so it can come from a flop
      awready_nxt = !aw_held_nxt && !bvalid_nxt;
      wready_nxt = !w_held_nxt && !bvalid_nxt;
   end

   always_comb begin
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (ar_take) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = `OCCR_RESP_OKAY;
         if ({s_axi_araddr[11:2], 2'b00} == `OCCR_SYNC_OUT7_OFS) begin
            rdata_nxt = {24'h000000, sync_cfg_r};
         end else if ({s_axi_araddr[11:2], 2'b00} == `OCCR_SEC_PATH_OFS) begin
            rdata_nxt = {24'h000000, sec_cfg_r};
         end else begin
            rdata_nxt = 32'h00000000;
            rresp_nxt = `OCCR_RESP_SLVERR;
         end
      end
      arready_nxt = !rvalid_nxt;
   end

   always_comb begin
      mute = sec_cfg_r[`OCCR_AUTO_MUTE_BIT] && fail_sync_r;
      out_nxt.multiframe_sync_out_enable = sync_cfg_r[`OCCR_MFS_EN_BIT];
      out_nxt.frame_sync_out_enable = sync_cfg_r[`OCCR_FS_EN_BIT];
      out_nxt.bits_out_enable = sync_cfg_r[`OCCR_BITS_EN_BIT] && !mute;
      out_nxt.composite_out_enable = sync_cfg_r[`OCCR_COMP_EN_BIT] && !mute;
      out_nxt.composite_duty_select = sec_cfg_r[`OCCR_DUTY_BIT];
      out_nxt.out7_select = sync_cfg_r[3:0];
      out_nxt.out7_enable = sync_cfg_r[3:0] != OUT7_OFF;
      // codes above the first digital rate come from the analog plls
      out_nxt.out7_from_main_pll = sync_cfg_r[3:0] > OUT7_DIG1 && sync_cfg_r[3:0] < 4'hb;
      out_nxt.out7_from_secondary_pll = sync_cfg_r[3:0] >= 4'hb;
   end

   // write side: both configuration words and the write channel state
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sync_cfg_r <= `OCCR_SYNC_OUT7_RST;
         sec_cfg_r <= `OCCR_SEC_PATH_RST;
         awaddr_r <= 12'h000;
         aw_held_r <= 1'b0;
         wdata_r <= 8'h00;
         wstrb0_r <= 1'b0;
         w_held_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'b00;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
      end else begin
         sync_cfg_r <= sync_cfg_nxt;
         sec_cfg_r <= sec_cfg_nxt;
         awaddr_r <= awaddr_nxt;
         aw_held_r <= aw_held_nxt;
         wdata_r <= wdata_nxt;
         wstrb0_r <= wstrb0_nxt;
         w_held_r <= w_held_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   reset_default_a: assert property (@(posedge sys_clk)
      reset |=> sync_cfg_r == `OCCR_SYNC_OUT7_RST && sec_cfg_r == `OCCR_SEC_PATH_RST)
      else $error("reset defaults not loaded");
   reset_bus_idle_a: assert property (@(posedge sys_clk)
      reset |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write channel busy after reset");
   write_resp_a: assert property (@(posedge sys_clk) disable iff (reset)
      do_write |=> s_axi_bvalid)
      else $error("write response missing");
   bresp_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
   write_block_a: assert property (@(posedge sys_clk) disable iff (reset)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while a response waits");
   sync_write_a: assert property (@(posedge sys_clk) disable iff (reset)
      do_write && wr_lane0 && hit_sync |=> sync_cfg_r == $past(wr_data))
      else $error("sync word write lost");
   sec_write_mask_a: assert property (@(posedge sys_clk) disable iff (reset)
      do_write && wr_lane0 && hit_sec |=> sec_cfg_r == ($past(wr_data) & `OCCR_SEC_PATH_MASK))
      else $error("secondary word write wrong");
   sec_top_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
      !sec_cfg_r[7])
      else $error("unused top bit set");
   no_strobe_keep_a: assert property (@(posedge sys_clk) disable iff (reset)
      do_write && !wr_lane0 |=> $stable(sync_cfg_r) && $stable(sec_cfg_r))
      else $error("write without lane 0 changed a word");
   bad_addr_err_a: assert property (@(posedge sys_clk) disable iff (reset)
      do_write && !hit_sync && !hit_sec |=> s_axi_bresp == `OCCR_RESP_SLVERR)
      else $error("unmapped write not refused");

   // read side: one answer at a time, captured when the address is taken
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rvalid_r <= 1'b0;
         rresp_r <= 2'b00;
         rdata_r <= 32'h00000000;
         arready_r <= 1'b1;
      end else begin
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         arready_r <= arready_nxt;
      end
   end

   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   read_idle_a: assert property (@(posedge sys_clk)
      reset |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel busy after reset");
   read_answer_a: assert property (@(posedge sys_clk) disable iff (reset)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   rdata_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      s_axi_rvalid && !s_axi_rready |=>
         s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer dropped before rready");
   read_block_a: assert property (@(posedge sys_clk) disable iff (reset)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while an answer waits");

   // failure flag comes from the pll domain, so it passes two flops first
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         fail_meta_r <= 1'b0;
         fail_sync_r <= 1'b0;
         out_r <= '0;
      end else begin
         fail_meta_r <= secondary_inputs_failed;
         fail_sync_r <= fail_meta_r;
         out_r <= out_nxt;
      end
   end

   assign out_ctrl = out_r;

   mute_blocks_bits_a: assert property (@(posedge sys_clk) disable iff (reset)
      sec_cfg_r[`OCCR_AUTO_MUTE_BIT] && fail_sync_r |=> !out_ctrl.bits_out_enable)
      else $error("bits output not muted on failure");
   mute_blocks_comp_a: assert property (@(posedge sys_clk) disable iff (reset)
      sec_cfg_r[`OCCR_AUTO_MUTE_BIT] && fail_sync_r |=> !out_ctrl.composite_out_enable)
      else $error("composite output not muted on failure");
   // reset also sits in the antecedents: the output flops still hold their
   // cleared value one edge after release, before the decode catches up
   no_mute_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
      !reset && !sec_cfg_r[`OCCR_AUTO_MUTE_BIT] |=>
         out_ctrl.bits_out_enable == $past(sync_cfg_r[`OCCR_BITS_EN_BIT]))
      else $error("bits output ignores its enable");
   comp_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
      !reset && !(sec_cfg_r[`OCCR_AUTO_MUTE_BIT] && fail_sync_r) |=>
         out_ctrl.composite_out_enable == $past(sync_cfg_r[`OCCR_COMP_EN_BIT]))
      else $error("composite output ignores its enable");
   bits_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
      !reset && !fail_sync_r |=>
         out_ctrl.bits_out_enable == $past(sync_cfg_r[`OCCR_BITS_EN_BIT]))
      else $error("bits output ignores its enable with inputs good");
   mfs_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
      !reset |=> out_ctrl.multiframe_sync_out_enable == $past(sync_cfg_r[`OCCR_MFS_EN_BIT]))
      else $error("multiframe sync enable wrong");
   fs_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
      !reset |=> out_ctrl.frame_sync_out_enable == $past(sync_cfg_r[`OCCR_FS_EN_BIT]))
      else $error("frame sync enable wrong");
   duty_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
      !reset |=> out_ctrl.composite_duty_select == $past(sec_cfg_r[`OCCR_DUTY_BIT]))
      else $error("duty select wrong");
   out7_src_a: assert property (@(posedge sys_clk) disable iff (reset)
      sync_cfg_r[3:0] == 4'hf |=> out_ctrl.out7_from_secondary_pll && out_ctrl.out7_enable)
      else $error("output seven source wrong");
   out7_off_a: assert property (@(posedge sys_clk) disable iff (reset)
      !reset && sync_cfg_r[3:0] == 4'h0 |=> !out_ctrl.out7_enable &&
         !out_ctrl.out7_from_main_pll && !out_ctrl.out7_from_secondary_pll)
      else $error("output seven not disabled");
   out7_main_a: assert property (@(posedge sys_clk) disable iff (reset)
      !reset && sync_cfg_r[3:0] inside {[4'h4:4'ha]} |=> out_ctrl.out7_enable &&
         out_ctrl.out7_from_main_pll && !out_ctrl.out7_from_secondary_pll)
      else $error("output seven main pll source wrong");
   out7_select_a: assert property (@(posedge sys_clk) disable iff (reset)
      !reset |=> out_ctrl.out7_select == $past(sync_cfg_r[3:0]))
      else $error("output seven code wrong");
endmodule

// ### tb.sv
`timescale 1ns/1ps
`include "occr_params.svh"
module tb;
   import occr_pkg::*;
   logic sys_clk = 1'b0, reset = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic secondary_inputs_failed = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] rd;
   occr_out_ctrl_type out_ctrl;
   int fail_count = 0, compares = 0;
   always #2 sys_clk = ~sys_clk;
   occr_output_clock_config_regs i_occr_output_clock_config_regs (.sys_clk(sys_clk),
      .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .secondary_inputs_failed(secondary_inputs_failed), .out_ctrl(out_ctrl));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // master holds each channel until its own handshake edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] strb);
      int n = 0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= strb;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 100) chk("write answer", 32'h1, 32'h0);
   endtask
   task automatic rdw(input logic [11:0] a);
      int n = 0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 100) chk("read answer", 32'h1, 32'h0);
   endtask
   task automatic test_reset();
      rdw(`OCCR_SYNC_OUT7_OFS);
      chk("sync reset", 32'h0000_00f6, rd);
      rdw(`OCCR_SEC_PATH_OFS);
      chk("sec reset", 32'h0, rd);
      chk("ctrl reset", 32'h0000_0f66, 32'(out_ctrl));
   endtask
   task automatic test_enables();
      for (int i = 0; i < 4; i++) begin
         wr(`OCCR_SYNC_OUT7_OFS, 8'(8'h80 >> i), 4'h1);
         repeat (2) @(posedge sys_clk);
         chk("enables", 32'(4'h8 >> i), 32'(out_ctrl[11:8]));
      end
   endtask
   task automatic test_out7();
      for (int c = 0; c < 16; c++) begin
         wr(`OCCR_SYNC_OUT7_OFS, {4'h0, 4'(c)}, 4'h1);
         repeat (2) @(posedge sys_clk);
         chk("out7", 32'({c != 0, c >= 4 && c <= 10, c >= 11, 4'(c)}), 32'(out_ctrl[6:0]));
      end
   endtask
   task automatic test_sec();
      wr(`OCCR_SEC_PATH_OFS, 8'hff, 4'h1);
      rdw(`OCCR_SEC_PATH_OFS);
      chk("sec top bit", 32'h7f, rd);
      chk("duty 5:8", 32'h1, 32'(out_ctrl.composite_duty_select));
      wr(`OCCR_SEC_PATH_OFS, 8'h00, 4'h1);
      repeat (2) @(posedge sys_clk);
      chk("duty 50:50", 32'h0, 32'(out_ctrl.composite_duty_select));
   endtask
   task automatic test_mute();
      wr(`OCCR_SYNC_OUT7_OFS, 8'h30, 4'h1);
      wr(`OCCR_SEC_PATH_OFS, 8'h40, 4'h1);
      secondary_inputs_failed <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk("muted", 32'h0, 32'(out_ctrl[9:8]));
      secondary_inputs_failed <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk("unmuted", 32'h3, 32'(out_ctrl[9:8]));
      wr(`OCCR_SEC_PATH_OFS, 8'h00, 4'h1);
      secondary_inputs_failed <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk("mute off", 32'h3, 32'(out_ctrl[9:8]));
      secondary_inputs_failed <= 1'b0;
   endtask
   task automatic test_bad_access();
      wr(12'h008, 8'h00, 4'h1);
      chk("unmapped bresp", 32'(`OCCR_RESP_SLVERR), 32'(rsp));
      rdw(12'h008);
      chk("unmapped rresp", 32'(`OCCR_RESP_SLVERR), 32'(rsp));
      chk("unmapped rdata", 32'h0, rd);
      // strobe off must leave the word alone
      wr(`OCCR_SYNC_OUT7_OFS, 8'h00, 4'h0);
      chk("no strobe bresp", 32'(`OCCR_RESP_OKAY), 32'(rsp));
      rdw(`OCCR_SYNC_OUT7_OFS);
      chk("no strobe data", 32'h30, rd);
   endtask
   task automatic test_done();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      test_reset();
      test_enables();
      test_out7();
      test_sec();
      test_mute();
      test_bad_access();
      test_done();
   end
   // generous span, whole run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      test_done();
   end
endmodule
